//--- fbd_burst_flash.sv
// flash side of a bitstream burst delivery to an fpga config port
// assumes config_clock, pins and reset are synchronous to clk_i
`include "fbd_params.svh"
module fbd_burst_flash #(
   parameter int POR_CYC = `FBD_POR_CYC,
   parameter int DEPTH = `FBD_MEM_DEPTH
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic config_clock_i,
   input wire logic chip_en_n_i,
   input wire logic out_en_n_i,
   input wire logic latch_en_n_i,
   input wire logic [`FBD_ADDR_W-1:0] addr_i,
   input wire logic ready_i,
   output logic ready_o,
   output logic ready_oe_o,
   input wire logic mem_we_i,
   input wire logic [$clog2(DEPTH)-1:0] mem_waddr_i,
   input wire logic [`FBD_DATA_W-1:0] mem_wdata_i,
   output logic [`FBD_DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic bursting_o
);
   localparam int AW = $clog2(DEPTH);

   // low address bits pick the word, upper bits wrap the store
   function automatic logic [AW-1:0] word_idx(
      input logic [`FBD_ADDR_W-1:0] a);
      return a[AW-1:0];
   endfunction

   fbd_pkg::fbd_regs_t s_r;
   fbd_pkg::fbd_regs_t s_nxt;
   logic [`FBD_DATA_W-1:0] mem_r [DEPTH];
   logic rise;
   logic rd_en;

   // edge seen on synchronous sample of config clock
   assign rise = config_clock_i & ~s_r.config_clock_q;
   assign rd_en = ~chip_en_n_i & ~out_en_n_i;

   // bitstream store, loaded by the programming side
   always_ff @(posedge clk_i)
   begin
      if (ce_i && mem_we_i)
      begin
         mem_r[mem_waddr_i] <= mem_wdata_i;
      end
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.config_clock_q = config_clock_i;
      case (s_r.st)
         fbd_pkg::FBD_RESET:
         begin
            s_nxt.pins.rdy_oe = 1'b1;
            s_nxt.pins.dq_oe = 1'b0;
            if (s_r.por_cnt >= 16'(POR_CYC - 1))
            begin
               s_nxt.pins.rdy_oe = 1'b0;
               s_nxt.st = fbd_pkg::FBD_WAIT_RDY;
            end
            else
            begin
               s_nxt.por_cnt = s_r.por_cnt + 16'h0001;
            end
         end
         fbd_pkg::FBD_WAIT_RDY:
         begin
            // wired-and line: high only when fpga released too
            if (ready_i)
            begin
               s_nxt.st = fbd_pkg::FBD_LATCH;
            end
         end
         fbd_pkg::FBD_LATCH:
         begin
            // latch enable must stay high through the sequence
            if (latch_en_n_i)
            begin
               s_nxt.addr = addr_i;
               s_nxt.pins.dq = mem_r[word_idx(addr_i)];
               s_nxt.pins.dq_oe = rd_en;
               s_nxt.st = fbd_pkg::FBD_BURST;
            end
         end
         fbd_pkg::FBD_BURST:
         begin
            s_nxt.pins.dq_oe = rd_en;
            if (!ready_i)
            begin
               // restart: system pulled ready low
               s_nxt.pins.dq_oe = 1'b0;
               s_nxt.st = fbd_pkg::FBD_WAIT_RDY;
            end
            else if (rise)
            begin
               // no wait states: a word every rise
               s_nxt.addr = s_r.addr + `FBD_ADDR_W'(1);
               // word-wide output only, no serial path
               s_nxt.pins.dq = mem_r[word_idx(s_r.addr + `FBD_ADDR_W'(1))];
            end
         end
         default:
         begin
            s_nxt.st = fbd_pkg::FBD_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_r <= '{st: fbd_pkg::FBD_RESET, por_cnt: 16'h0000,
                  addr: '0, config_clock_q: 1'b0,
                  pins: '{rdy_oe: 1'b1, dq_oe: 1'b0, dq: '0}};
      end
      else if (ce_i)
      begin
         s_r <= s_nxt;
      end
   end

   // open drain: only ever drives low
   assign ready_o = 1'b0;
   assign ready_oe_o = s_r.pins.rdy_oe;
   assign dq_o = s_r.pins.dq;
   assign dq_oe_o = s_r.pins.dq_oe;
   assign bursting_o = (s_r.st == fbd_pkg::FBD_BURST);

   a_ready_hold: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (s_r.st == fbd_pkg::FBD_RESET)
      |-> ready_oe_o)
      else $error("ready released before internal ready");
   a_burst_gate: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && $rose(bursting_o)
      |-> $past(ready_i))
      else $error("burst began before ready line high");
   a_addr_step: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && rise && ready_i
      |=> s_r.addr == $past(s_r.addr) + `FBD_ADDR_W'(1))
      else $error("address did not advance on clock rise");
   a_addr_hold: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && !rise
      |=> s_r.addr == $past(s_r.addr))
      else $error("address moved without clock rise");
   a_start_addr: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && s_r.st == fbd_pkg::FBD_LATCH && latch_en_n_i
      |=> s_r.addr == $past(addr_i))
      else $error("start address not taken from pins");
   a_reset_entry: assert property (
      @(posedge clk_i)
      $rose(rstn_i)
      |-> s_r.st == fbd_pkg::FBD_RESET)
      else $error("reset did not enter start sequence");

   a_dq_step: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && rise && ready_i
      |=> dq_o == $past(mem_r[word_idx(s_r.addr + `FBD_ADDR_W'(1))]))
      else $error("next word not presented on clock rise");
   a_dq_hold: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && !rise && ready_i
      |=> $stable(dq_o))
      else $error("data changed without clock rise");
   a_drive_gate: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      dq_oe_o
      |-> bursting_o)
      else $error("data driven outside burst");
   a_oe_follow: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && ready_i
      |=> dq_oe_o == $past(rd_en))
      else $error("data drive does not follow read enables");
   // a restart must drop the bus at once, else two words collide
   a_restart_exit: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && bursting_o && !ready_i
      |=> !bursting_o && !dq_oe_o)
      else $error("burst kept running with ready line low");
   a_wait_hold: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && s_r.st == fbd_pkg::FBD_WAIT_RDY && !ready_i
      |=> s_r.st == fbd_pkg::FBD_WAIT_RDY)
      else $error("left wait state with ready line low");
   a_latch_wait: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && s_r.st == fbd_pkg::FBD_LATCH && !latch_en_n_i
      |=> s_r.st == fbd_pkg::FBD_LATCH)
      else $error("latch sequence ran with latch enable low");
   a_por_done: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      !ready_oe_o
      |-> s_r.por_cnt >= 16'(POR_CYC - 1))
      else $error("ready released before power-on count");
endmodule

//--- fbd_params.svh
// constants for the bitstream burst delivery block
// assumes inclusion by bare name from package and design
`ifndef FBD_PARAMS_SVH
`define FBD_PARAMS_SVH
`define FBD_DATA_W 16
`define FBD_ADDR_W 23
`define FBD_CLK_MHZ 250
`define FBD_POR_NS 1000
`define FBD_POR_CYC ((`FBD_POR_NS * `FBD_CLK_MHZ + 999) / 1000)
`define FBD_MEM_DEPTH 64
`endif

//--- fbd_pkg.sv
// types for the bitstream burst delivery block
// assumes fbd_params.svh is on the include path
`include "fbd_params.svh"
package fbd_pkg;
   typedef enum logic [3:0] {
      FBD_RESET = 4'h1,
      FBD_WAIT_RDY = 4'h2,
      FBD_LATCH = 4'h4,
      FBD_BURST = 4'h8
   } fbd_state_t;
   typedef struct packed {
      logic rdy_oe;
      logic dq_oe;
      logic [`FBD_DATA_W-1:0] dq;
   } fbd_pins_t;
   typedef struct packed {
      fbd_state_t st;
      logic [15:0] por_cnt;
      logic [`FBD_ADDR_W-1:0] addr;
      logic config_clock_q;
      fbd_pins_t pins;
   } fbd_regs_t;
endpackage

//--- fbd_fpga_model.sv
// fpga config port model: init line and config clock
// assumes wired-and ready line is resolved by the bench
module fbd_fpga_model (
   input wire logic clk_i,
   input wire logic rel_i,
   input wire logic run_i,
   output logic init_oe_o = 1'b1,
   output logic config_clock_o = 1'b0,
   output logic done_o = 1'b0
);
   // externally clocked parallel mode: no image fallback retry
   localparam logic [2:0] MODE_SEL = 3'b110;
   logic [2:0] mode_q = 3'b000;
   logic ran = 1'b0;
   // clock stands still outside bursts and until mode is sampled
   always @(negedge clk_i)
   begin
      init_oe_o <= !rel_i;
      if (rel_i && init_oe_o)
      begin
         mode_q <= MODE_SEL;
      end
      ran <= rel_i && (ran || run_i);
      done_o <= rel_i && ran && !run_i;
      config_clock_o <= run_i && !config_clock_o
         && (mode_q == MODE_SEL);
   end
endmodule

//--- fbd_burst_flash_tb.sv
// bench for the bitstream burst delivery block
// assumes fbd_fpga_model and the design are compiled first
`define CHK(n, e, s) num_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end
module fbd_burst_flash_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, rel = 0, run = 0, we = 0;
   logic latch_n = 1, oe_n = 0, done;
   logic [5:0] wa = '0;
   logic [15:0] wd = '0;
   logic [22:0] addr = '0;
   logic ready_oe, dq_oe, burst, init_oe, cc;
   logic [15:0] dq;
   wire rdy = !(ready_oe | init_oe);
   int fail_count = 0, num_checks = 0;
   always #2 clk = ~clk;
   fbd_burst_flash #(.POR_CYC(4)) fbd_burst_flash_i (.clk_i(clk),
      .rstn_i(rstn), .ce_i(1'b1), .config_clock_i(cc), .chip_en_n_i(1'b0),
      .out_en_n_i(oe_n), .latch_en_n_i(latch_n), .addr_i(addr), .ready_i(rdy),
      .ready_o(), .ready_oe_o(ready_oe), .mem_we_i(we), .mem_waddr_i(wa),
      .mem_wdata_i(wd), .dq_o(dq), .dq_oe_o(dq_oe), .bursting_o(burst));
   fbd_fpga_model fbd_fpga_model_i (.clk_i(clk), .rel_i(rel), .run_i(run),
      .init_oe_o(init_oe), .config_clock_o(cc), .done_o(done));
   function automatic logic [15:0] w(input int i);
      return 16'ha000 | 16'(i & 63);
   endfunction
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // release init, then one word per rise from start address a
   task check_burst(input int a);
      int k;
      k = 0;
      @(negedge clk);
      rel <= 1;
      repeat (40) if (burst !== 1'b1) @(negedge clk);
      `CHK("bursting", 1'b1, burst)
      `CHK("drive", 1'b1, dq_oe)
      run <= 1;
      // cc seen at a falling edge is what the last rising edge sampled
      repeat (20)
      begin
         @(negedge clk);
         if (cc)
         begin
            k++;
         end
         `CHK("word", w(a + k), dq)
      end
      @(negedge clk);
      run <= 0;
      repeat (2) @(negedge clk);
      `CHK("done", 1'b1, done)
   endtask
   task check_latch_hold;
      @(negedge clk);
      latch_n <= 0;
      rel <= 1;
      repeat (6) @(negedge clk);
      `CHK("latch held", 1'b0, burst)
      latch_n <= 1;
   endtask
   task check_oe;
      @(negedge clk);
      oe_n <= 1;
      @(negedge clk);
      `CHK("oe off", 1'b0, dq_oe)
      oe_n <= 0;
      @(negedge clk);
      `CHK("oe on", 1'b1, dq_oe)
   endtask
   task restart;
      @(negedge clk);
      rel <= 0;
      addr <= 23'h5;
      repeat (5) @(negedge clk);
      `CHK("stopped", 1'b0, burst)
      `CHK("undriven", 1'b0, dq_oe)
   endtask
   initial
   begin
      #20000;
      fail_count++;
      final_report;
   end
   initial
   begin
      repeat (8) @(negedge clk);
      `CHK("rst ready", 1'b1, ready_oe)
      `CHK("rst drive", 1'b0, dq_oe)
      rstn <= 1;
      // preload while the fpga still holds init low
      for (int i = 0; i < 64; i++)
      begin
         @(negedge clk);
         we <= 1;
         wa <= i[5:0];
         wd <= w(i);
      end
      @(negedge clk);
      we <= 0;
      `CHK("por end", 1'b0, ready_oe)
      `CHK("held", 1'b0, burst)
      check_burst(0);
      restart;
      check_latch_hold;
      check_burst(5);
      check_oe;
      final_report;
   end
endmodule
